//--- spwc_bench.sv
// randomised self-checking bench for the serial pin and width control block
`timescale 1ns/1ns
module spwc_bench;
	logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wait_mode_i = 1'b0;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, q;
	logic        ack_o, irq_o, sck_o, sck_oe_o, ss_n_o, ss_n_oe_o, p_sck, p_ss_n, p_mosi;
	logic        mosi_o, mosi_oe_o, miso_o, miso_oe_o, p_miso;
	logic [15:0] rnd = 16'h5e97;
	logic [23:0] tbl [5] = '{24'h004004, 24'h001004, 24'h000104, 24'h000801, 24'h010904};
	int          n_errors = 0, checked = 0, ticks = 0, i;
	wire         sck_w  = sck_oe_o ? sck_o : p_sck;
	wire         ss_w   = ss_n_oe_o ? ss_n_o : p_ss_n;
	wire         mosi_w = mosi_oe_o ? mosi_o : p_mosi;
	wire         miso_w = miso_oe_o ? miso_o : p_miso;
	spwc_top #(.HALF_CYC(4)) dut (.clk_i, .rst_i, .ce_i, .wait_mode_i, .cyc_i, .stb_i, .we_i,
		.adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .sck_i(sck_w), .sck_o, .sck_oe_o,
		.ss_n_i(ss_w), .ss_n_o, .ss_n_oe_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o,
		.miso_i(miso_w), .miso_o, .miso_oe_o);
	spwc_peer peer (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(p_sck),
		.ss_n_o(p_ss_n), .mosi_o(p_mosi), .miso_o(p_miso));
	initial forever #50 clk_i = ~clk_i;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// narrow frames carry the low byte only
	function automatic logic [31:0] mk(input logic w, input logic [15:0] v);
		return {16'h0, w ? v : {8'h00, v[7:0]}};
	endfunction
	task automatic complete_run();
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic start(input logic [7:0] c2, input logic [15:0] d);
		peer.tx_ff = c2[6] ? rnd : {rnd[7:0], 8'h00};
		wb(1'b1, spwc_pkg::ADR_CONTROL_2, {24'h0, c2});
		wb(1'b1, spwc_pkg::ADR_DATA, {16'h0, d});
	endtask
	// status read must also drop the interrupt
	task automatic fin(input logic [31:0] st);
		for (i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clk_i);
		rd(spwc_pkg::ADR_STATUS, st, "status");
		@(posedge clk_i);
		chk("irq after clear", 32'h0, {31'h0, irq_o});
	endtask
	task automatic xfer(input logic [7:0] c2);
		logic [15:0] d;
		d = lfsr(rnd);
		rnd = lfsr(d);
		start(c2, d);
		fin(32'h1);
		rd(spwc_pkg::ADR_DATA, mk(c2[6], rnd), "rx word");
		chk("tx word", mk(c2[6], d), mk(c2[6], peer.rx_ff));
	endtask
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 10000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(spwc_pkg::ADR_CONTROL_2, 32'h0, "ctrl2 reset");
		rd(spwc_pkg::ADR_STATUS, 32'h0, "status reset");
		rd(8'h14, 32'h0, "unmapped");
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			wb(1'b1, spwc_pkg::ADR_CONTROL_2, {24'h0, rnd[7:0]});
			rd(spwc_pkg::ADR_CONTROL_2, {24'h0, rnd[7:0] & 8'h5b}, "ctrl2");
		end
		wb(1'b1, spwc_pkg::ADR_CONTROL_1, 32'h3);
		start(8'h00, 16'h0011);
		repeat (150) @(posedge clk_i);
		chk("masked irq", 32'h0, {31'h0, irq_o});
		wb(1'b1, spwc_pkg::ADR_IRQ_MASK, 32'h7);
		fin(32'h1);
		for (int k = 0; k < 4; k++)
			xfer({1'b0, k[0], 6'h00});
		// output enable change aborts only with single-wire pins
		foreach (tbl[k]) begin
			start(tbl[k][23:16], rnd);
			repeat (20) @(posedge clk_i);
			if (tbl[k][16])
				chk("mosi oe", 32'h0, {31'h0, mosi_oe_o});
			wb(1'b1, spwc_pkg::ADR_CONTROL_2, {24'h0, tbl[k][15:8]});
			fin({24'h0, tbl[k][7:0]});
		end
		wait_mode_i <= 1'b1;
		xfer(8'h00);
		start(8'h02, rnd);
		repeat (200) @(posedge clk_i);
		chk("frozen irq", 32'h0, {31'h0, irq_o});
		wait_mode_i <= 1'b0;
		fin(32'h1);
		peer.ss_n_o <= 1'b0;
		xfer(8'h00);
		wb(1'b1, spwc_pkg::ADR_CONTROL_2, 32'h10);
		fin(32'h2);
		rd(spwc_pkg::ADR_CONTROL_1, 32'h1, "master after fault");
		peer.ss_n_o <= 1'b1;
		wb(1'b1, spwc_pkg::ADR_CONTROL_2, 32'h0);
		wb(1'b1, spwc_pkg::ADR_DATA, {16'h0, rnd});
		peer.send(rnd[15:8]);
		fin(32'h1);
		rd(spwc_pkg::ADR_DATA, {24'h0, rnd[15:8]}, "slave rx");
		chk("slave tx", {24'h0, rnd[7:0]}, {24'h0, peer.rx_ff[7:0]});
		// single-wire slave with its buffer on ignores the other line, reads its own word
		wb(1'b1, spwc_pkg::ADR_CONTROL_2, 32'h09);
		rnd = lfsr(rnd);
		wb(1'b1, spwc_pkg::ADR_DATA, {16'h0, rnd});
		peer.send(~rnd[7:0]);
		fin(32'h1);
		rd(spwc_pkg::ADR_DATA, {24'h0, rnd[7:0]}, "single wire rx");
		chk("single wire tx", {24'h0, rnd[7:0]}, {24'h0, peer.rx_ff[7:0]});
		complete_run();
	end
endmodule

//--- spwc_chk.sv
// port assertions for the serial pin and width control block
`timescale 1ns/1ns
module spwc_chk #(
	parameter int HALF_CYC = 4
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wait_mode_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        sck_o,
	input wire logic        sck_oe_o,
	input wire logic        ss_n_oe_o,
	input wire logic        mosi_oe_o,
	input wire logic        miso_oe_o
);
	logic [7:0] c2_ff;
	logic [7:0] hcnt_ff;
	logic       sck_q_ff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			c2_ff <= 8'h00;
		else if (cyc_i && stb_i && ack_o && we_i && adr_i == spwc_pkg::ADR_CONTROL_2)
			c2_ff <= dat_i[7:0] & 8'h5b;
	end
	// frozen with the clock in wait, so a stopped phase still counts true
	always_ff @(posedge clk_i) begin
		sck_q_ff <= sck_o;
		if (rst_i)
			hcnt_ff <= 8'hff;
		else if (sck_o != sck_q_ff)
			hcnt_ff <= 8'h00;
		else if (hcnt_ff != 8'hff && !(wait_mode_i && c2_ff[1]))
			hcnt_ff <= hcnt_ff + 8'h01;
	end
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_rd(logic [7:0] a);
		s_req ##0 (!we_i && adr_i == a);
	endsequence
	AST_ACK_PULSE: assert property (s_req |=> ack_o ##1 !ack_o)
		else $error("ack not a single pulse");
	AST_UNMAPPED: assert property (s_rd(8'h14) |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL2_READ: assert property (s_rd(spwc_pkg::ADR_CONTROL_2) |=> dat_o == {24'h0, c2_ff})
		else $error("control 2 read back wrong");
	AST_SELECT_IN: assert property (!ss_n_oe_o)
		else $error("select pin driven");
	AST_OUT_MASTER: assert property (mosi_oe_o |-> sck_oe_o && !miso_oe_o)
		else $error("master out enabled outside master");
	AST_BIDIR_MASTER: assert property (sck_oe_o && c2_ff[0] && !c2_ff[3] && $stable(c2_ff) |-> !mosi_oe_o)
		else $error("single wire master drives with buffer off");
	AST_BIDIR_SLAVE: assert property (miso_oe_o && $stable(c2_ff) |-> !c2_ff[0] || c2_ff[3])
		else $error("slave out buffer on while disabled");
	AST_WAIT_STOP: assert property (sck_oe_o && wait_mode_i && $past(wait_mode_i) && c2_ff[1] |=> $stable(sck_o))
		else $error("serial clock moved in wait");
	AST_HALF_PERIOD: assert property ($rose(sck_o) && hcnt_ff < 8'h08 |-> hcnt_ff == HALF_CYC - 1)
		else $error("serial clock low phase wrong");
endmodule
bind spwc_top spwc_chk #(.HALF_CYC(HALF_CYC)) chk (.clk_i, .rst_i, .wait_mode_i, .cyc_i, .stb_i,
	.we_i, .adr_i, .dat_i, .dat_o, .ack_o, .sck_o, .sck_oe_o, .ss_n_oe_o, .mosi_oe_o, .miso_oe_o);

//--- spwc_peer.sv
// far-side serial device: answers the unit as master or leads it as slave
`timescale 1ns/1ns
module spwc_peer (
	input  wire logic sck_i,
	input  wire logic mosi_i,
	input  wire logic miso_i,
	output logic      sck_o,
	output logic      ss_n_o,
	output logic      mosi_o,
	output logic      miso_o
);
	logic [15:0] tx_ff = 16'h0000;
	logic [15:0] rx_ff = 16'h0000;
	logic        lead  = 1'b0;
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	assign miso_o = tx_ff[15];
	// msb first, sampled on the rising edge
	always @(posedge sck_i)
		rx_ff <= {rx_ff[14:0], lead ? miso_i : mosi_i};
	// refill with a changing pattern so a stale line never looks right
	always @(negedge sck_i)
		tx_ff <= {tx_ff[14:0], ~tx_ff[0]};
	// pin changes fall on clock edges; non-blocking keeps the sampling order fixed
	task automatic send(input logic [7:0] w);
		lead = 1'b1;
		ss_n_o <= 1'b0;
		#800;
		for (int b = 7; b >= 0; b--) begin
			mosi_o <= w[b];
			#400 sck_o <= 1'b1;
			#400 sck_o <= 1'b0;
		end
		#400 ss_n_o <= 1'b1;
		mosi_o <= ~w[0];
		lead = 1'b0;
	endtask
endmodule

//--- spwc_pkg.sv
// constants, field layout and types for the serial pin and width control block
package spwc_pkg;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          SCK_PERIOD_NS  = 800;
	localparam int          SCK_HALF_CYC   = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) /
		(2 * CLK_PERIOD_NS);
	localparam int          PIN_COUNT      = 4;
	localparam int          DATA_W         = 16;
	localparam int          BITCNT_W       = 5;
	localparam logic [4:0]  BITS_NARROW    = 5'h08;
	localparam logic [4:0]  BITS_WIDE      = 5'h10;
	// register byte addresses
	localparam logic [7:0]  ADR_CONTROL_1  = 8'h00;
	localparam logic [7:0]  ADR_CONTROL_2  = 8'h04;
	localparam logic [7:0]  ADR_DATA       = 8'h08;
	localparam logic [7:0]  ADR_STATUS     = 8'h0c;
	localparam logic [7:0]  ADR_IRQ_MASK   = 8'h10;
	// serial_port_control_2 field positions
	localparam int          POS_TRANSFER_WIDTH_SELECT_SEL   = 6;
	localparam int          POS_MODE_FAULT_FLAG_EN    = 4;
	localparam int          POS_BIDIR_OE   = 3;
	localparam int          POS_STOP_WAIT  = 1;
	localparam int          POS_PIN_CTRL   = 0;
	// control_1 and status field positions
	localparam int          POS_ENABLE     = 0;
	localparam int          POS_MASTER     = 1;
	localparam int          POS_ST_DONE    = 0;
	localparam int          POS_ST_MODE_FAULT_FLAG    = 1;
	localparam int          POS_ST_ABORT   = 2;
	localparam int          EVT_W          = 3;
	// reset values
	localparam logic [1:0]  CONTROL_1_RST  = 2'h0;
	localparam logic [2:0]  MASK_RST       = 3'h0;
	localparam logic [2:0]  STATUS_RST     = 3'h0;

	typedef struct packed {
		logic transfer_width_select;
		logic mode_fault_enable;
		logic bidir_output_enable;
		logic stop_clock_in_wait;
		logic serial_pin_control;
	} spwc_ctrl2_type;

	localparam spwc_ctrl2_type CONTROL_2_RST = '0;

	// synchronised pin levels travel together
	typedef struct packed {
		logic sck;
		logic ss_n;
		logic mosi;
		logic miso;
	} spwc_pins_type;

	typedef enum logic [1:0] {
		SPWC_IDLE   = 2'b00,
		SPWC_MASTER = 2'b01,
		SPWC_SLAVE  = 2'b10
	} spwc_state_type;
endpackage

//--- spwc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module spwc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;

	if (WIDTH < 1) begin : g_chk
		$error("spwc_sync: WIDTH must be at least 1");
	end

	// first stage is read only by the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_o  <= '0;
		end else if (ce_i) begin
			meta_ff <= async_i;
			sync_o  <= meta_ff;
		end
	end
endmodule

//--- spwc_top.sv
// serial port pin, width and wait control with a wishbone register slave
// Functional notes
// RQ1 - exactly four pins: data out/in, data in/out, serial clock, slave select
// RQ2 - normal mode: master drives master-out line, slave samples it
// RQ3 - width bit 6: 0 uses low byte only, 1 uses both bytes
// RQ4 - as master, changing width, fault enable or pin control aborts to idle
// RQ5 - fault enable clear in master mode: select pin unused, no fault check
// RQ6 - fault enable set: select pin watched and a fault is flagged
// RQ7 - slave mode: select pin is only an input whatever fault enable says
// RQ8 - bit 3 enables the master-out buffer as master, slave-out as slave
// RQ9 - master with bidirectional pins: changing output enable aborts to idle
// RQ10 - bit 1 set halts serial clock generation in wait mode
// RQ11 - bit 0 selects single-wire bidirectional pins, clear gives separate pins
// RQ12 - master bidirectional: master-in unused, master-out is the single data wire
// RQ13 - slave bidirectional: master-out unused, slave-out is the single data wire
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ns
module spwc_top #(
	parameter int HALF_CYC = spwc_pkg::SCK_HALF_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wait_mode_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             irq_o,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_o,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe_o,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe_o,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe_o
);
	if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_chk
		$error("spwc_top: HALF_CYC must lie in 1..255");
	end

	spwc_pkg::spwc_ctrl2_type       ctrl2_ff;
	spwc_pkg::spwc_ctrl2_type       wr_ctrl2;
	spwc_pkg::spwc_pins_type        pins_s;
	spwc_pkg::spwc_state_type       st_ff;
	logic [1:0]                     ctrl1_ff;
	logic [spwc_pkg::EVT_W-1:0]     stat_ff;
	logic [spwc_pkg::EVT_W-1:0]     mask_ff;
	logic [spwc_pkg::EVT_W-1:0]     evt_set;
	logic [spwc_pkg::EVT_W-1:0]     evt_clr;
	logic [spwc_pkg::DATA_W-1:0]    tx_ff;
	logic [spwc_pkg::DATA_W-1:0]    rx_ff;
	logic [spwc_pkg::DATA_W-1:0]    sh_ff;
	logic [spwc_pkg::BITCNT_W-1:0]  bit_ff;
	logic [spwc_pkg::BITCNT_W-1:0]  bits_n;
	logic [7:0]                     cnt_ff;
	logic                           sck_ff;
	logic                           sck_q_ff;
	logic                           ack_ff;
	logic                           tx_pend_ff;
	logic                           wb_req;
	logic                           wb_wr;
	logic                           wb_rd;
	logic                           is_master;
	logic                           enabled;
	logic                           din;
	logic                           obit;
	logic                           halt;
	logic                           tick;
	logic                           abort;
	logic                           fault;
	logic                           done;
	logic                           sck_rise;
	logic                           last_bit;
	logic                           in_ff;
	logic                           nbit;

	spwc_sync #(
		.WIDTH (spwc_pkg::PIN_COUNT)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.async_i ({sck_i, ss_n_i, mosi_i, miso_i}),
		.sync_o  (pins_s)
	);

	// wishbone classic: ack one cycle after the request, writes land on the ack edge
	assign wb_req = cyc_i & stb_i;
	assign wb_wr  = wb_req & ack_ff & we_i & sel_i[0];
	assign wb_rd  = wb_req & ack_ff & ~we_i;
	assign ack_o  = ack_ff;

	assign enabled   = ctrl1_ff[spwc_pkg::POS_ENABLE];
	assign is_master = ctrl1_ff[spwc_pkg::POS_MASTER];

	always_comb begin
		wr_ctrl2.transfer_width_select = dat_i[spwc_pkg::POS_TRANSFER_WIDTH_SELECT_SEL];
		wr_ctrl2.mode_fault_enable     = dat_i[spwc_pkg::POS_MODE_FAULT_FLAG_EN];
		wr_ctrl2.bidir_output_enable   = dat_i[spwc_pkg::POS_BIDIR_OE];
		wr_ctrl2.stop_clock_in_wait    = dat_i[spwc_pkg::POS_STOP_WAIT];
		wr_ctrl2.serial_pin_control    = dat_i[spwc_pkg::POS_PIN_CTRL];
	end

	// a master-side reconfiguration of the pins or width ends any frame
	always_comb begin
		abort = 1'b0;
		if (wb_wr && adr_i == spwc_pkg::ADR_CONTROL_2 && is_master) begin
			if (wr_ctrl2.transfer_width_select != ctrl2_ff.transfer_width_select ||
				wr_ctrl2.mode_fault_enable != ctrl2_ff.mode_fault_enable ||
				wr_ctrl2.serial_pin_control != ctrl2_ff.serial_pin_control) begin
				abort = 1'b1; // see RQ4
			end
			if (ctrl2_ff.serial_pin_control &&
				wr_ctrl2.bidir_output_enable != ctrl2_ff.bidir_output_enable) begin
				abort = 1'b1; // see RQ9
			end
		end
	end

	// select pin watched for a fault only when master with fault enable; no fault check otherwise
	assign fault = enabled & is_master & ctrl2_ff.mode_fault_enable & ~pins_s.ss_n; // see RQ6 RQ5

	assign bits_n = ctrl2_ff.transfer_width_select ? spwc_pkg::BITS_WIDE
		: spwc_pkg::BITS_NARROW; // see RQ3
	assign obit   = ctrl2_ff.transfer_width_select ? sh_ff[15] : sh_ff[7];

	// single-wire mode swaps which pin carries incoming data
	always_comb begin
		if (is_master) begin
			din = ctrl2_ff.serial_pin_control ? pins_s.mosi : pins_s.miso; // see RQ12 RQ2
		end else begin
			din = ctrl2_ff.serial_pin_control ? pins_s.miso : pins_s.mosi; // see RQ13 RQ2
		end
	end

	assign halt     = ctrl2_ff.stop_clock_in_wait & wait_mode_i; // see RQ10
	assign tick     = (st_ff == spwc_pkg::SPWC_MASTER) && !halt &&
		cnt_ff == 8'(HALF_CYC - 1);
	assign sck_rise = pins_s.sck & ~sck_q_ff;
	assign last_bit = bit_ff == bits_n;
	// master takes the bit latched at its rising edge, slave the pin itself
	assign nbit     = (st_ff == spwc_pkg::SPWC_MASTER) ? in_ff : din;

	always_comb begin
		done = 1'b0;
		if (st_ff == spwc_pkg::SPWC_MASTER && tick && sck_ff && last_bit) begin
			done = 1'b1;
		end
		if (st_ff == spwc_pkg::SPWC_SLAVE && sck_rise &&
			bit_ff == bits_n - 5'h01) begin
			done = 1'b1;
		end
	end

	always_comb begin
		evt_set                          = '0;
		evt_set[spwc_pkg::POS_ST_DONE]   = done;
		evt_set[spwc_pkg::POS_ST_MODE_FAULT_FLAG]   = fault;
		evt_set[spwc_pkg::POS_ST_ABORT]  = abort & (st_ff == spwc_pkg::SPWC_MASTER);
		evt_clr                          = '0;
		if (wb_rd && adr_i == spwc_pkg::ADR_STATUS) begin
			evt_clr = '1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_o  <= '0;
		end else if (ce_i) begin
			ack_ff <= wb_req & ~ack_ff;
			if (wb_req && !ack_ff) begin
				unique case (adr_i)
					spwc_pkg::ADR_CONTROL_1: dat_o <= {30'h0, ctrl1_ff};
					spwc_pkg::ADR_CONTROL_2: dat_o <= {25'h0,
						ctrl2_ff.transfer_width_select, 1'b0,
						ctrl2_ff.mode_fault_enable, ctrl2_ff.bidir_output_enable,
						1'b0, ctrl2_ff.stop_clock_in_wait,
						ctrl2_ff.serial_pin_control};
					spwc_pkg::ADR_DATA:      dat_o <= {16'h0, rx_ff};
					spwc_pkg::ADR_STATUS:    dat_o <= {29'h0, stat_ff};
					spwc_pkg::ADR_IRQ_MASK:  dat_o <= {29'h0, mask_ff};
					default:                 dat_o <= '0;
				endcase
			end
		end
	end

	// control registers; a mode fault throws the unit out of master mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl1_ff <= spwc_pkg::CONTROL_1_RST;
			ctrl2_ff <= spwc_pkg::CONTROL_2_RST;
			mask_ff  <= spwc_pkg::MASK_RST;
		end else if (ce_i) begin
			if (wb_wr && adr_i == spwc_pkg::ADR_CONTROL_1) begin
				ctrl1_ff <= dat_i[1:0];
			end
			if (fault) begin
				ctrl1_ff[spwc_pkg::POS_MASTER] <= 1'b0; // see RQ6
			end
			if (wb_wr && adr_i == spwc_pkg::ADR_CONTROL_2) begin
				ctrl2_ff <= wr_ctrl2; // see RQ11
			end
			if (wb_wr && adr_i == spwc_pkg::ADR_IRQ_MASK) begin
				mask_ff <= dat_i[spwc_pkg::EVT_W-1:0];
			end
		end
	end

	// sticky events: a new event in the clearing cycle survives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_ff <= spwc_pkg::STATUS_RST;
		end else if (ce_i) begin
			stat_ff <= (stat_ff & ~evt_clr) | evt_set;
		end
	end

	assign irq_o = |(stat_ff & mask_ff);

	// transmit word: high byte only written when its lane is selected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_ff      <= '0;
			tx_pend_ff <= 1'b0;
		end else if (ce_i) begin
			if (wb_wr && adr_i == spwc_pkg::ADR_DATA) begin
				tx_ff[7:0] <= dat_i[7:0];
				if (sel_i[1]) begin
					tx_ff[15:8] <= dat_i[15:8];
				end
				tx_pend_ff <= 1'b1;
			end else if (st_ff == spwc_pkg::SPWC_IDLE && tx_pend_ff && enabled) begin
				tx_pend_ff <= 1'b0;
			end
		end
	end

	// shift engine: master generates the clock, slave follows the sampled one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff    <= spwc_pkg::SPWC_IDLE;
			sh_ff    <= '0;
			rx_ff    <= '0;
			bit_ff   <= '0;
			cnt_ff   <= '0;
			sck_ff   <= 1'b0;
			sck_q_ff <= 1'b0;
			in_ff    <= 1'b0;
		end else if (ce_i) begin
			sck_q_ff <= pins_s.sck;
			if (done) begin
				rx_ff <= ctrl2_ff.transfer_width_select ? {sh_ff[14:0], nbit}
					: {8'h00, sh_ff[6:0], nbit}; // see RQ3
			end
			unique case (st_ff)
				spwc_pkg::SPWC_IDLE: begin
					sck_ff <= 1'b0;
					cnt_ff <= '0;
					bit_ff <= '0;
					if (enabled && tx_pend_ff) begin
						sh_ff <= tx_ff;
					end
					if (enabled && is_master && tx_pend_ff && !fault) begin
						st_ff <= spwc_pkg::SPWC_MASTER;
					end else if (enabled && !is_master && !pins_s.ss_n) begin
						st_ff <= spwc_pkg::SPWC_SLAVE; // see RQ7
					end
				end
				spwc_pkg::SPWC_MASTER: begin
					if (abort || fault || !enabled || !is_master) begin
						st_ff  <= spwc_pkg::SPWC_IDLE; // see RQ4 RQ9
						sck_ff <= 1'b0;
					end else if (!halt) begin
						cnt_ff <= tick ? 8'h00 : cnt_ff + 8'h01;
						if (tick) begin
							sck_ff <= ~sck_ff;
							// out bit moves on the falling edge so it is settled at the rise
							if (!sck_ff) begin
								in_ff  <= din;
								bit_ff <= bit_ff + 5'h01;
							end else begin
								sh_ff <= {sh_ff[14:0], in_ff};
								if (last_bit) begin
									st_ff <= spwc_pkg::SPWC_IDLE;
								end
							end
						end
					end
				end
				spwc_pkg::SPWC_SLAVE: begin
					if (pins_s.ss_n || !enabled || is_master) begin
						st_ff <= spwc_pkg::SPWC_IDLE; // see RQ7
					end else if (sck_rise) begin
						sh_ff  <= {sh_ff[14:0], din};
						bit_ff <= done ? 5'h00 : bit_ff + 5'h01;
					end
				end
				default: st_ff <= spwc_pkg::SPWC_IDLE;
			endcase
		end
	end

	// pin drivers; the select pin is never driven by this unit
	assign sck_o     = sck_ff;
	assign sck_oe_o  = enabled & is_master; // see RQ1
	assign ss_n_o    = 1'b0;
	assign ss_n_oe_o = 1'b0; // see RQ5 RQ7
	assign mosi_o    = is_master & obit;
	assign miso_o    = ~is_master & obit;
	assign mosi_oe_o = enabled & is_master &
		(~ctrl2_ff.serial_pin_control | ctrl2_ff.bidir_output_enable); // see RQ2 RQ8 RQ12
	assign miso_oe_o = enabled & ~is_master & ~pins_s.ss_n &
		(~ctrl2_ff.serial_pin_control | ctrl2_ff.bidir_output_enable); // see RQ8 RQ13
endmodule
